/* module_state_pkg.sv */
// Constants for the module state status and control bank
package module_state_pkg;
  localparam int NUM_MODULES = 11;
  localparam int NUM_DOMAINS = 5;
  localparam int CORE_MODULE = 1;
  // Modules 1 and 5 start enabled
  localparam logic [10:0] ENABLED_AT_RESET = 11'h022;
  // Owning power domain of each module
  localparam logic [2:0] MODULE_DOMAIN [0:10] = '{3'h0, 3'h0, 3'h0, 3'h0,
    3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  // Register offsets
  localparam logic [11:0] STATUS_BASE = 12'h800;
  localparam logic [11:0] CONTROL_BASE = 12'hA00;
  localparam logic [11:0] TRANSITION_CMD_OFFSET = 12'h120;
  localparam logic [11:0] TRANSITION_STATUS_OFFSET = 12'h128;
  // Field positions
  localparam int CLOCK_RUNNING_BIT = 12;
  localparam int RESET_DONE_BIT = 11;
  localparam int RESET_LINE_BIT = 10;
  localparam int LOCAL_DONE_BIT = 9;
  localparam int LOCAL_RESET_BIT = 8;
  // State codes
  localparam logic [5:0] STATE_SW_RESET_DISABLED = 6'h00;
  localparam logic [5:0] STATE_ENABLE = 6'h03;
  localparam logic [4:0] NEXT_ENABLE = 5'h03;
  localparam logic [4:0] NEXT_DISABLED = 5'h00;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int TRANSITION_TIME_NS = 40;
  localparam logic [3:0] TRANSITION_CYCLES =
    4'((TRANSITION_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* module_state_status_control.sv */
// Module state status and control bank with AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module module_state_status_control #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [10:0] module_clock_enable,
  output logic [10:0] module_reset_n,
  output logic core_local_reset_n
);
  localparam int NM = module_state_pkg::NUM_MODULES;
  localparam int ND = module_state_pkg::NUM_DOMAINS;
  localparam int CM = module_state_pkg::CORE_MODULE;

  // ==========================================================
  // Declarations
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [11:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] rdata_next, rd_word;
  logic rd_ok, wr_ok, wr_fire;
  logic [NM-1:0] enabled_reg, enabled_next, done_reg, done_next, pend;
  logic [4:0] next_state_reg [NM];
  logic [4:0] next_state_next [NM];
  logic local_ctl_reg, local_ctl_next, local_done_reg, local_done_next;
  logic [3:0] cnt_reg [ND];
  logic [3:0] cnt_next [ND];
  logic [ND-1:0] busy;
  logic [31:0] status_word [NM];
  logic [11:0] ra, wa;

  // ==========================================================
  // Status words and decode
  always_comb
  begin
    for (int d = 0; d < ND; d++)
    begin
      busy[d] = (cnt_reg[d] != 4'h0);
    end
    for (int i = 0; i < NM; i++)
    begin
      status_word[i] = 32'h0;
      status_word[i][module_state_pkg::CLOCK_RUNNING_BIT] =
        module_clock_enable[i];
      status_word[i][module_state_pkg::RESET_DONE_BIT] = done_reg[i];
      status_word[i][module_state_pkg::RESET_LINE_BIT] = module_reset_n[i];
      status_word[i][module_state_pkg::LOCAL_DONE_BIT] =
        (i == CM) ? local_done_reg : 1'b1;
      status_word[i][module_state_pkg::LOCAL_RESET_BIT] =
        (i == CM) ? core_local_reset_n : 1'b0;
      status_word[i][5:0] = enabled_reg[i] ?
        module_state_pkg::STATE_ENABLE :
        module_state_pkg::STATE_SW_RESET_DISABLED;
    end
    ra = 12'(s_axi_araddr);
    rd_ok = 1'b1;
    rd_word = 32'h0;
    if (ra[11:6] == module_state_pkg::STATUS_BASE[11:6] &&
        ra[5:2] < 4'(NM) && ra[1:0] == 2'h0)
      rd_word = status_word[ra[5:2]];
    else if (ra[11:6] == module_state_pkg::CONTROL_BASE[11:6] &&
             ra[5:2] < 4'(NM) && ra[1:0] == 2'h0)
    begin
      rd_word[4:0] = next_state_reg[ra[5:2]];
      rd_word[module_state_pkg::LOCAL_RESET_BIT] =
        (ra[5:2] == 4'(CM)) ? local_ctl_reg : 1'b0;
    end
    else if (ra == module_state_pkg::TRANSITION_STATUS_OFFSET)
      rd_word[ND-1:0] = busy;
    else if (ra != module_state_pkg::TRANSITION_CMD_OFFSET)
      rd_ok = 1'b0;
    wa = awaddr_reg;
    wr_ok = ((wa[11:6] == module_state_pkg::CONTROL_BASE[11:6] ||
              wa[11:6] == module_state_pkg::STATUS_BASE[11:6]) &&
             wa[5:2] < 4'(NM) && wa[1:0] == 2'h0) ||
            wa == module_state_pkg::TRANSITION_CMD_OFFSET ||
            wa == module_state_pkg::TRANSITION_STATUS_OFFSET;
  end

  // ==========================================================
  // AXI4-Lite handshakes
  always_comb
  begin
    aw_have_next = aw_have_reg;
    awaddr_next = awaddr_reg;
    w_have_next = w_have_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = s_axi_bvalid;
    bresp_next = s_axi_bresp;
    rvalid_next = s_axi_rvalid;
    rdata_next = s_axi_rdata;
    rresp_next = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_next = 1'b1;
      awaddr_next = 12'(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      bvalid_next = 1'b0;
    wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
    if (wr_fire)
    begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_ok ? module_state_pkg::RESP_OKAY :
        module_state_pkg::RESP_SLVERR;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rdata_next = rd_ok ? rd_word : 32'h0;
      rresp_next = rd_ok ? module_state_pkg::RESP_OKAY :
        module_state_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      rvalid_next = 1'b0;
    awready_next = !aw_have_next && !bvalid_next;
    wready_next = !w_have_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      s_axi_awready <= awready_next;
      s_axi_wready <= wready_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
      s_axi_arready <= arready_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rresp_next;
    end
  end

  // ==========================================================
  // Module states and domain transitions
  always_comb
  begin
    enabled_next = enabled_reg;
    local_ctl_next = local_ctl_reg;
    for (int i = 0; i < NM; i++)
      next_state_next[i] = next_state_reg[i];
    for (int d = 0; d < ND; d++)
      cnt_next[d] = busy[d] ? cnt_reg[d] - 4'h1 : 4'h0;
    if (wr_fire && wa[11:6] == module_state_pkg::CONTROL_BASE[11:6] &&
        wa[5:2] < 4'(NM) && wa[1:0] == 2'h0)
    begin
      if (wstrb_reg[0])
        next_state_next[wa[5:2]] = wdata_reg[4:0];
      if (wstrb_reg[1] && wa[5:2] == 4'(CM))
        local_ctl_next = wdata_reg[module_state_pkg::LOCAL_RESET_BIT];
    end
    if (wr_fire && wa == module_state_pkg::TRANSITION_CMD_OFFSET &&
        wstrb_reg[0])
      for (int d = 0; d < ND; d++)
        if (wdata_reg[d] && !busy[d])
          cnt_next[d] = module_state_pkg::TRANSITION_CYCLES;
    for (int i = 0; i < NM; i++)
    begin
      pend[i] = busy[module_state_pkg::MODULE_DOMAIN[i]] &&
        ((next_state_reg[i] == module_state_pkg::NEXT_ENABLE &&
          !enabled_reg[i]) ||
         (next_state_reg[i] == module_state_pkg::NEXT_DISABLED &&
          enabled_reg[i]));
      if (pend[i] && cnt_reg[module_state_pkg::MODULE_DOMAIN[i]] == 4'h1)
        enabled_next[i] = !enabled_reg[i];
      done_next[i] = !pend[i];
    end
    local_done_next = (core_local_reset_n == local_ctl_reg);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enabled_reg <= module_state_pkg::ENABLED_AT_RESET;
      done_reg <= '1;
      local_ctl_reg <= 1'b0;
      local_done_reg <= 1'b1;
      core_local_reset_n <= 1'b0;
      module_clock_enable <= module_state_pkg::ENABLED_AT_RESET;
      module_reset_n <= module_state_pkg::ENABLED_AT_RESET;
      for (int i = 0; i < NM; i++)
        next_state_reg[i] <= module_state_pkg::ENABLED_AT_RESET[i] ?
          module_state_pkg::NEXT_ENABLE : module_state_pkg::NEXT_DISABLED;
      for (int d = 0; d < ND; d++)
        cnt_reg[d] <= 4'h0;
    end
    else
    begin
      enabled_reg <= enabled_next;
      done_reg <= done_next;
      local_ctl_reg <= local_ctl_next;
      local_done_reg <= local_done_next;
      core_local_reset_n <= local_ctl_reg;
      module_clock_enable <= enabled_reg;
      module_reset_n <= enabled_reg;
      for (int i = 0; i < NM; i++)
        next_state_reg[i] <= next_state_next[i];
      for (int d = 0; d < ND; d++)
        cnt_reg[d] <= cnt_next[d];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_local_change;
    $changed(local_ctl_reg);
  endsequence
  sequence s_local_settle;
    !local_done_reg ##1 local_done_reg;
  endsequence
  AST_CLOCK_FOLLOWS: assert property ($rose(enabled_reg[2]) |=>
    module_clock_enable[2]) else $error("clock status does not follow state");
  AST_DONE_LOW: assert property ((pend != '0) |=>
    (done_reg & $past(pend)) == '0) else $error("reset done during change");
  AST_RESET_MIRROR: assert property ($fell(enabled_reg[2]) |=>
    !module_reset_n[2] && !status_word[2][10]) else $error("bad reset mirror");
  AST_LOCAL_DONE: assert property (s_local_change |->
    ##1 s_local_settle) else $error("local reset done sequence wrong");
  AST_LOCAL_LINE: assert property (s_local_change |=>
    core_local_reset_n == local_ctl_reg ##1
    status_word[CM][8] == local_ctl_reg) else $error("local reset pin wrong");
  AST_APPLY_ONLY_GO: assert property ($changed(enabled_reg) |->
    $past(busy != '0)) else $error("state changed without transition");
  AST_GO_BUSY: assert property ($rose(busy[0]) |->
    busy[0][*8] ##1 !busy[0]) else $error("transition status length wrong");
  AST_STATE_CODE: assert property (enabled_reg[2] |->
    status_word[2][5:0] == 6'h03) else $error("enable state code wrong");
  AST_RESET_DEFAULT: assert property (disable iff (1'b0)
    !aresetn |=> next_state_reg[1] == 5'h03 && next_state_reg[0] == 5'h00)
    else $error("control reset value wrong");
  AST_RESERVED_ZERO: assert property (s_axi_rvalid |->
    s_axi_rdata[31:13] == 19'h0) else $error("reserved bits read nonzero");
endmodule

/* tb_top.sv */
// Self-checking bench for the module state status and control bank
`timescale 1ns/1ps
module tb_top;
  logic aclk = 0;
  logic aresetn = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, core_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [10:0] clk_en, rst_n;
  logic [31:0] lf = 32'h1AF5;
  logic [31:0] d;
  logic [1:0] r;
  int err_count = 0, n_compared = 0, m;
  always #2.5 aclk = ~aclk;
  module_state_status_control u_module_state_status_control (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .module_clock_enable(clk_en), .module_reset_n(rst_n),
    .core_local_reset_n(core_n));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] st_a(input int i);
    return module_state_pkg::STATUS_BASE + 12'(4 * i);
  endfunction
  function automatic logic [11:0] ct_a(input int i);
    return module_state_pkg::CONTROL_BASE + 12'(4 * i);
  endfunction
  function automatic logic [31:0] st_exp(input int i, input logic en,
                                         input logic lrel);
    logic [31:0] v;
    v = 32'h0000_0A00;
    v[12] = en;
    v[10] = en;
    v[8] = (i == 1) ? lrel : 1'b0;
    v[5:0] = en ? module_state_pkg::STATE_ENABLE : 6'h00;
    return v;
  endfunction
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_word(input string n, input logic [31:0] e,
                          input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_resp(input string n, input logic [1:0] e,
                          input logic [1:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    int t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (t = 0; t < 100; t++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid === 1'b1 && bready)
      begin
        rs = bresp;
        bready <= 0;
        break;
      end
    end
    if (t == 100) chk_word("write timeout", 0, 1);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    int t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (t = 0; t < 100; t++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid === 1'b1 && rready)
      begin
        v = rdata;
        rs = rresp;
        rready <= 0;
        break;
      end
    end
    if (t == 100) chk_word("read timeout", 0, 1);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                        input logic [31:0] k);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    chk_resp("rresp", module_state_pkg::RESP_OKAY, rs);
    chk_word("rdata", e & k, v & k);
  endtask
  // ==========================================================
  // Watchdog
  initial
  begin
    #100000;
    err_count++;
    end_of_test();
  end
  // ==========================================================
  // Tests
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 11; i++)
    begin
      m = (i == 1 || i == 5) ? 3 : 0;
      rd_chk(ct_a(i), 32'(m), 32'hFFFF_FFFF);
      rd_chk(st_a(i), st_exp(i, m == 3, 0), (i == 1) ? ~32'h200 : '1);
    end
    chk_word("clk_en", 32'h22, 32'(clk_en));
    $display("test reset values done");
    for (int k = 0; k < 10; k++)
    begin
      lf = lfsr(lf);
      m = (k < 2) ? k : int'(lf[7:0]) % 11;
      d = (k == 2) ? 32'hFFFF_FFFF : lfsr(lf);
      wr(ct_a(m), d, r);
      chk_resp("bresp", module_state_pkg::RESP_OKAY, r);
      rd_chk(ct_a(m), d & ((m == 1) ? 32'h11F : 32'h1F), '1);
      chk_word("clk_en", 32'h22, 32'(clk_en));
      wr(ct_a(m), (m == 1 || m == 5) ? 32'h3 : 32'h0, r);
    end
    $display("test random control done");
    for (int dm = 0; dm < 5; dm++)
    begin
      m = (dm == 0) ? 2 : 6 + dm;
      wr(ct_a(m), 32'h3, r);
      chk_word("pins", 0, {30'h0, clk_en[m], rst_n[m]});
      wr(module_state_pkg::TRANSITION_CMD_OFFSET, 32'(1 << dm), r);
      rd_chk(module_state_pkg::TRANSITION_STATUS_OFFSET, 32'(1 << dm), '1);
      repeat (12) @(posedge aclk);
      rd_chk(module_state_pkg::TRANSITION_STATUS_OFFSET, 0, '1);
      chk_word("pins", 3, {30'h0, clk_en[m], rst_n[m]});
      rd_chk(st_a(m), st_exp(m, 1, 0), '1);
    end
    wr(ct_a(2), 32'h0, r);
    wr(module_state_pkg::TRANSITION_CMD_OFFSET, 32'h1, r);
    rd_chk(st_a(2), 0, 32'h800);
    repeat (12) @(posedge aclk);
    rd_chk(st_a(2), st_exp(2, 0, 0), '1);
    chk_word("pins", 0, {30'h0, clk_en[2], rst_n[2]});
    $display("test transitions done");
    wr(ct_a(1), 32'h103, r);
    repeat (4) @(posedge aclk);
    chk_word("core_n", 1, 32'(core_n));
    rd_chk(st_a(1), st_exp(1, 1, 1), '1);
    wr(ct_a(1), 32'h003, r);
    repeat (4) @(posedge aclk);
    chk_word("core_n", 0, 32'(core_n));
    rd_chk(st_a(1), 0, 32'h100);
    $display("test local reset done");
    wr(12'h400, 32'hFFFF_FFFF, r);
    chk_resp("bresp", module_state_pkg::RESP_SLVERR, r);
    rd(12'h400, d, r);
    chk_resp("rresp", module_state_pkg::RESP_SLVERR, r);
    chk_word("rdata", 0, d);
    wr(st_a(3), 32'hFFFF_FFFF, r);
    chk_resp("bresp", module_state_pkg::RESP_OKAY, r);
    rd_chk(st_a(3), st_exp(3, 0, 0), '1);
    $display("test refusals done");
    end_of_test();
  end
endmodule
